// ==== include/rbkl_params.svh ====
/*
 * Constants for the reset boot kernel loader: addresses, counts, timing.
 * Assumes a 50 MHz system clock and a 48-bit internal instruction memory.
 */
`ifndef RBKL_PARAMS_SVH
`define RBKL_PARAMS_SVH

`define RBKL_KERNEL_WORDS    9'h100
`define RBKL_WORD_BITS       48
`define RBKL_START_ADDR      20'h40000
`define RBKL_RESET_VEC_ADDR  20'h40004
`define RBKL_EPROM_BASE      32'h00800000
`define RBKL_EPROM_WAITS     3'h6
`define RBKL_EPROM_BYTES     3'h6
`define RBKL_HOST16_HALVES   3'h3
`define RBKL_LINK_NIBBLES    4'hC
`define RBKL_LINK_BUFFER     3'h4
`define RBKL_FIFO_DEPTH      8

`endif

// ==== include/rbkl_pkg.sv ====
/*
 * Types for the reset boot kernel loader.
 * Assumes rbkl_params.svh constants for widths.
 */
package rbkl_pkg;
    typedef enum logic [2:0] {
        RBKL_MODE_NOBOOT,
        RBKL_MODE_HOST,
        RBKL_MODE_LINK,
        RBKL_MODE_EPROM,
        RBKL_MODE_RESERVED
    } rbkl_mode_t;

    typedef enum logic [1:0] {
        RBKL_CH_NONE,
        RBKL_CH_LINK,
        RBKL_CH_EXT
    } rbkl_chan_t;

    typedef struct packed {
        logic [19:0] addr;
        logic [47:0] data;
    } rbkl_imem_wr_t;

    typedef struct packed {
        logic        wide;
        logic [15:0] data;
    } rbkl_host_word_t;
endpackage

// ==== src/rbkl_fifo.sv ====
/*
 * Parameterised synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
module rbkl_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_reset,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign o_in_ready  = (cnt_q != DEPTH[AW:0]);
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data  = mem_q[rd_q];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

// ==== src/rbkl_loader.sv ====
/*
 * Reset boot kernel loader: picks boot source from straps, packs data
 * into 48-bit words, writes 256 of them to internal memory, then starts.
 * Assumes straps are stable at reset release and the internal memory
 * accepts one write per cycle when ready.
 */
`timescale 1ns/1ps
`include "rbkl_params.svh"
module rbkl_loader (
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_reset,
    input  wire logic                    i_eprom_boot_select,
    input  wire logic                    i_link_boot_select,
    input  wire logic                    i_boot_memory_select,
    output logic                         o_boot_memory_select,
    output logic                         o_boot_memory_select_oe_n,
    output logic [31:0]                  o_ext_addr,
    output logic                         o_ext_rd_n,
    input  wire logic [7:0]              i_ext_data,
    input  wire logic                    i_host_valid,
    input  wire rbkl_pkg::rbkl_host_word_t i_host_word,
    output logic                         o_host_ready,
    input  wire logic                    i_link_valid,
    input  wire logic [3:0]              i_link_data,
    input  wire logic [2:0]              i_link_buffer,
    output logic                         o_link_ready,
    output logic                         o_imem_wr_en,
    output rbkl_pkg::rbkl_imem_wr_t      o_imem_wr,
    input  wire logic                    i_imem_ready,
    output rbkl_pkg::rbkl_chan_t         o_dma_channel,
    output rbkl_pkg::rbkl_mode_t         o_boot_mode,
    output logic                         o_core_idle,
    output logic                         o_core_run,
    output logic [19:0]                  o_core_pc,
    output logic                         o_ext_exec
);
    import rbkl_pkg::*;

    typedef enum logic [2:0] {
        ST_SAMPLE,
        ST_DECIDE,
        ST_LOAD,
        ST_DRAIN,
        ST_RUN,
        ST_EXTRUN,
        ST_HALT
    } rbkl_state_t;

    rbkl_state_t state_q;
    rbkl_mode_t  mode_q;
    logic [2:0]  eb_s_q, lb_s_q, bm_s_q;
    logic [8:0]  count_q;
    logic [47:0] pack_q;
    logic [3:0]  slots_q;
    logic        pack_full_q;
    logic [2:0]  wait_q;
    logic        rd_pend_q;
    logic [7:0]  ext_s1_q, ext_s2_q;
    logic        host_v_s1_q, host_v_s2_q;
    logic        link_v_s1_q, link_v_s2_q;
    rbkl_host_word_t host_s1_q, host_s2_q;
    logic [3:0]  link_s1_q, link_s2_q;
    logic [2:0]  lbuf_s1_q, lbuf_s2_q;
    logic        host_ack_q, link_ack_q;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic [47:0] fifo_out_data;
    logic [19:0] wr_addr_q;
    logic [3:0]  slots_need;

    // pin-side data and handshake inputs pass two flops first; straps pass three
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            ext_s1_q    <= '0;
            ext_s2_q    <= '0;
            host_v_s1_q <= 1'b0;
            host_v_s2_q <= 1'b0;
            link_v_s1_q <= 1'b0;
            link_v_s2_q <= 1'b0;
            host_s1_q   <= '0;
            host_s2_q   <= '0;
            link_s1_q   <= '0;
            link_s2_q   <= '0;
            lbuf_s1_q   <= '0;
            lbuf_s2_q   <= '0;
        end else begin
            ext_s1_q    <= i_ext_data;
            ext_s2_q    <= ext_s1_q;
            host_v_s1_q <= i_host_valid;
            host_v_s2_q <= host_v_s1_q;
            link_v_s1_q <= i_link_valid;
            link_v_s2_q <= link_v_s1_q;
            host_s1_q   <= i_host_word;
            host_s2_q   <= host_s1_q;
            link_s1_q   <= i_link_data;
            link_s2_q   <= link_s1_q;
            lbuf_s1_q   <= i_link_buffer;
            lbuf_s2_q   <= lbuf_s1_q;
        end
    end

    // straps keep sampling through reset, so the decision at the second
    // edge after release sees settled levels instead of reset zeros
    always_ff @(posedge i_clk_sys) begin
        eb_s_q <= {eb_s_q[1:0], i_eprom_boot_select};
        lb_s_q <= {lb_s_q[1:0], i_link_boot_select};
        bm_s_q <= {bm_s_q[1:0], i_boot_memory_select};
    end

    always_comb begin
        slots_need = 4'h0;
        case (mode_q)
            RBKL_MODE_EPROM: slots_need = {1'b0, `RBKL_EPROM_BYTES};
            RBKL_MODE_HOST:  slots_need = host_s2_q.wide ?
                                 {1'b0, `RBKL_HOST16_HALVES} : 4'h6;
            RBKL_MODE_LINK:  slots_need = `RBKL_LINK_NIBBLES;
            default:         slots_need = 4'h0;
        endcase
    end

    // main sequencer
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            state_q <= ST_SAMPLE;
            mode_q  <= RBKL_MODE_NOBOOT;
        end else begin
            case (state_q)
                ST_SAMPLE: state_q <= ST_DECIDE;
                ST_DECIDE: begin
                    if (eb_s_q[2] && !lb_s_q[2]) begin
                        mode_q  <= RBKL_MODE_EPROM;
                        state_q <= ST_LOAD;
                    end else if (!eb_s_q[2] && lb_s_q[2] && bm_s_q[2]) begin
                        mode_q  <= RBKL_MODE_LINK;
                        state_q <= ST_LOAD;
                    end else if (!eb_s_q[2] && !lb_s_q[2]) begin
                        if (bm_s_q[2]) begin
                            mode_q  <= RBKL_MODE_HOST;
                            state_q <= ST_LOAD;
                        end else begin
                            mode_q  <= RBKL_MODE_NOBOOT;
                            state_q <= ST_EXTRUN;
                        end
                    end else begin
                        mode_q  <= RBKL_MODE_RESERVED;
                        state_q <= ST_HALT;
                    end
                end
                ST_LOAD: begin
                    if (count_q == 9'h000) begin
                        state_q <= ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    if (!fifo_out_valid && !o_imem_wr_en) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN:    state_q <= ST_RUN;
                ST_EXTRUN: state_q <= ST_EXTRUN;
                ST_HALT:   state_q <= ST_HALT;
                default:   state_q <= ST_HALT;
            endcase
        end
    end

    // packing of narrow transfers, low part first
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            pack_q      <= '0;
            slots_q     <= '0;
            pack_full_q <= 1'b0;
            count_q     <= `RBKL_KERNEL_WORDS;
            wait_q      <= '0;
            rd_pend_q   <= 1'b0;
            o_ext_addr  <= '0;
            o_ext_rd_n  <= 1'b1;
            host_ack_q  <= 1'b0;
            link_ack_q  <= 1'b0;
        end else begin
            host_ack_q <= 1'b0;
            link_ack_q <= 1'b0;
            if (state_q == ST_DECIDE) begin
                o_ext_addr <= `RBKL_EPROM_BASE;
            end
            if (pack_full_q && fifo_in_ready) begin
                pack_full_q <= 1'b0;
                count_q     <= count_q - 9'h001;
            end
            if (state_q == ST_LOAD && count_q != 9'h000 && !pack_full_q) begin
                case (mode_q)
                    RBKL_MODE_EPROM: begin
                        if (!rd_pend_q) begin
                            rd_pend_q  <= 1'b1;
                            o_ext_rd_n <= 1'b0;
                            wait_q     <= '0;
                        end else if (wait_q != `RBKL_EPROM_WAITS) begin
                            wait_q <= wait_q + 3'h1;
                        end else begin
                            rd_pend_q  <= 1'b0;
                            o_ext_rd_n <= 1'b1;
                            o_ext_addr <= o_ext_addr + 32'h1;
                            pack_q <= {ext_s2_q, pack_q[47:8]};
                            if (slots_q + 4'h1 == slots_need) begin
                                slots_q     <= '0;
                                pack_full_q <= 1'b1;
                            end else begin
                                slots_q <= slots_q + 4'h1;
                            end
                        end
                    end
                    RBKL_MODE_HOST: begin
                        if (host_v_s2_q && !host_ack_q && !o_host_ready) begin
                            host_ack_q <= 1'b1;
                            if (host_s2_q.wide) begin
                                pack_q <= {host_s2_q.data, pack_q[47:16]};
                            end else begin
                                pack_q <= {host_s2_q.data[7:0], pack_q[47:8]};
                            end
                            if (slots_q + 4'h1 == slots_need) begin
                                slots_q     <= '0;
                                pack_full_q <= 1'b1;
                            end else begin
                                slots_q <= slots_q + 4'h1;
                            end
                        end
                    end
                    RBKL_MODE_LINK: begin
                        if (link_v_s2_q && !link_ack_q && !o_link_ready &&
                            lbuf_s2_q == `RBKL_LINK_BUFFER) begin
                            link_ack_q <= 1'b1;
                            pack_q     <= {link_s2_q, pack_q[47:4]};
                            if (slots_q + 4'h1 == slots_need) begin
                                slots_q     <= '0;
                                pack_full_q <= 1'b1;
                            end else begin
                                slots_q <= slots_q + 4'h1;
                            end
                        end
                    end
                    default: slots_q <= slots_q;
                endcase
            end
        end
    end

    // four-phase handshake: ready stands until the source drops valid
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_host_ready <= 1'b0;
            o_link_ready <= 1'b0;
        end else begin
            if (host_ack_q) begin
                o_host_ready <= 1'b1;
            end else if (!host_v_s2_q) begin
                o_host_ready <= 1'b0;
            end
            if (link_ack_q) begin
                o_link_ready <= 1'b1;
            end else if (!link_v_s2_q) begin
                o_link_ready <= 1'b0;
            end
        end
    end

    rbkl_fifo #(
        .WIDTH (`RBKL_WORD_BITS),
        .DEPTH (`RBKL_FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys   (i_clk_sys),
        .i_reset     (i_reset),
        .i_in_valid  (pack_full_q),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (pack_q),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (i_imem_ready),
        .o_out_data  (fifo_out_data)
    );

    // internal memory writes from the kernel start address upward
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            wr_addr_q    <= `RBKL_START_ADDR;
            o_imem_wr_en <= 1'b0;
            o_imem_wr    <= '0;
        end else begin
            o_imem_wr_en <= fifo_out_valid && i_imem_ready;
            if (fifo_out_valid && i_imem_ready) begin
                o_imem_wr.addr <= wr_addr_q;
                o_imem_wr.data <= fifo_out_data;
                wr_addr_q      <= wr_addr_q + 20'h1;
            end
        end
    end

    // status and chip-select outputs
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_boot_memory_select      <= 1'b1;
            o_boot_memory_select_oe_n <= 1'b1;
            o_dma_channel             <= RBKL_CH_NONE;
            o_boot_mode               <= RBKL_MODE_NOBOOT;
            o_core_idle               <= 1'b1;
            o_core_run                <= 1'b0;
            o_core_pc                 <= `RBKL_RESET_VEC_ADDR;
            o_ext_exec                <= 1'b0;
        end else begin
            o_boot_mode <= mode_q;
            // chip select only driven while the EPROM load runs
            o_boot_memory_select_oe_n <= !(mode_q == RBKL_MODE_EPROM &&
                                           state_q == ST_LOAD);
            o_boot_memory_select <= o_ext_rd_n;
            if (state_q == ST_LOAD) begin
                o_dma_channel <= (mode_q == RBKL_MODE_LINK) ?
                                 RBKL_CH_LINK : RBKL_CH_EXT;
            end else begin
                o_dma_channel <= RBKL_CH_NONE;
            end
            o_core_idle <= !(state_q == ST_RUN || state_q == ST_EXTRUN);
            o_core_run  <= (state_q == ST_RUN);
            o_ext_exec  <= (state_q == ST_EXTRUN);
            if (state_q == ST_RUN) begin
                // reset vector is skipped; image holds a no-op there
                o_core_pc <= `RBKL_START_ADDR;
            end
        end
    end
endmodule

// ==== dv/rbkl_loader_asserts.sv ====
/* Port-level checker for rbkl_loader, bound to every instance.
   Assumes one clock and the asynchronous active-high reset. */
`timescale 1ns/1ps
module rbkl_loader_asserts (
    input wire logic                    i_clk_sys,
    input wire logic                    i_reset,
    input wire logic                    o_boot_memory_select,
    input wire logic                    o_boot_memory_select_oe_n,
    input wire logic [31:0]             o_ext_addr,
    input wire logic                    o_ext_rd_n,
    input wire logic                    o_imem_wr_en,
    input wire rbkl_pkg::rbkl_imem_wr_t o_imem_wr,
    input wire rbkl_pkg::rbkl_chan_t    o_dma_channel,
    input wire rbkl_pkg::rbkl_mode_t    o_boot_mode,
    input wire logic                    o_core_idle,
    input wire logic                    o_core_run,
    input wire logic [19:0]             o_core_pc,
    input wire logic                    o_ext_exec
);
    import rbkl_pkg::*;
    logic [8:0] wr_cnt_q;
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset)
            wr_cnt_q <= 9'h000;
        else if (o_imem_wr_en)
            wr_cnt_q <= wr_cnt_q + 9'h001;
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    rd_len_a: assert property (
        $fell(o_ext_rd_n) |-> !o_ext_rd_n [*7] ##1 o_ext_rd_n)
        else $error("read strobe length wrong");
    addr_step_a: assert property (
        $changed(o_ext_addr) && $past(o_ext_addr) != 32'h0
        && !o_boot_memory_select_oe_n && $past(!o_boot_memory_select_oe_n)
        |-> o_ext_addr == $past(o_ext_addr) + 32'h1)
        else $error("boot address did not step by one");
    rd_range_a: assert property (
        !o_ext_rd_n |-> o_ext_addr >= 32'h00800000
        && o_ext_addr < 32'h00800600)
        else $error("read outside kernel bytes");
    cs_follow_a: assert property (
        !o_boot_memory_select_oe_n && $past(!o_boot_memory_select_oe_n)
        |-> o_boot_memory_select == $past(o_ext_rd_n))
        else $error("chip select not trailing strobe");
    cs_mode_a: assert property (
        !o_boot_memory_select_oe_n |-> o_boot_mode == RBKL_MODE_EPROM)
        else $error("select pin driven outside eprom mode");
    chan_link_a: assert property (
        o_dma_channel == RBKL_CH_LINK |-> o_boot_mode == RBKL_MODE_LINK)
        else $error("link channel in wrong mode");
    chan_ext_a: assert property (
        o_dma_channel == RBKL_CH_EXT
        |-> o_boot_mode inside {RBKL_MODE_HOST, RBKL_MODE_EPROM})
        else $error("external channel in wrong mode");
    wr_addr_a: assert property (
        o_imem_wr_en |-> wr_cnt_q < 9'h100
        && o_imem_wr.addr == 20'h40000 + {11'h0, wr_cnt_q})
        else $error("kernel write address wrong");
    run_pc_a: assert property (
        o_core_run |-> o_core_pc == 20'h40000 && !o_core_idle)
        else $error("run without start address");
    run_after_a: assert property (
        $rose(o_core_run) |-> wr_cnt_q == 9'h100)
        else $error("run before full kernel");
    noboot_a: assert property (
        o_ext_exec |-> !o_imem_wr_en && o_ext_rd_n && !o_core_run)
        else $error("kernel load in no-boot mode");
endmodule

bind rbkl_loader rbkl_loader_asserts u_chk (
    .i_clk_sys, .i_reset, .o_boot_memory_select,
    .o_boot_memory_select_oe_n, .o_ext_addr, .o_ext_rd_n, .o_imem_wr_en,
    .o_imem_wr, .o_dma_channel, .o_boot_mode, .o_core_idle, .o_core_run,
    .o_core_pc, .o_ext_exec
);

// ==== dv/rbkl_eprom_model.sv ====
/* Byte-wide boot memory model; ACCESS sets its access time in cycles.
   Assumes active-low read strobe and chip select from the loader. */
`timescale 1ns/1ps
module rbkl_eprom_model #(
    parameter int ACCESS = 1
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rd_n,
    input  wire logic        i_cs_n,
    input  wire logic [31:0] i_addr,
    output logic [7:0]       o_data = 8'h00
);
    logic [3:0] cnt_q = 4'h0;
    always_ff @(posedge i_clk_sys) begin
        if (i_rd_n || i_cs_n)
            cnt_q <= 4'h0;
        else if (cnt_q != 4'hF)
            cnt_q <= cnt_q + 4'h1;
        // released or still in access time: bus wanders every cycle
        if (!i_rd_n && !i_cs_n && cnt_q >= 4'(ACCESS))
            o_data <= i_addr[7:0] ^ i_addr[15:8] ^ 8'hA5;
        else
            o_data <= ~o_data;
    end
endmodule

// ==== dv/tb_top.sv ====
/* Self-checking bench for rbkl_loader in every boot mode.
   Assumes a pull-up on the select pin and the eprom model on the bus. */
`timescale 1ns/1ps
module tb_top;
    import rbkl_pkg::*;
    logic i_clk_sys = 1'b0, i_reset = 1'b1, bms_strap = 1'b1;
    logic i_eprom_boot_select = 1'b0, i_link_boot_select = 1'b0;
    logic i_host_valid = 1'b0, i_link_valid = 1'b0, i_imem_ready = 1'b1;
    logic [3:0] i_link_data = 4'h0;
    logic [2:0] i_link_buffer = 3'h0;
    rbkl_host_word_t i_host_word = '0;
    logic i_boot_memory_select, o_boot_memory_select;
    logic o_boot_memory_select_oe_n, o_ext_rd_n, o_host_ready;
    logic o_link_ready, o_imem_wr_en, o_core_idle, o_core_run, o_ext_exec;
    logic [7:0] i_ext_data;
    logic [31:0] o_ext_addr;
    logic [19:0] o_core_pc;
    rbkl_imem_wr_t o_imem_wr;
    rbkl_chan_t o_dma_channel;
    rbkl_mode_t o_boot_mode;
    int failures = 0, n_tests = 0, mode_sel = 0, wcnt = 0;
    assign i_boot_memory_select = o_boot_memory_select_oe_n ? bms_strap
                                                            : o_boot_memory_select;
    always #10 i_clk_sys = ~i_clk_sys;
    rbkl_loader dut (.i_clk_sys, .i_reset, .i_eprom_boot_select,
        .i_link_boot_select, .i_boot_memory_select, .o_boot_memory_select,
        .o_boot_memory_select_oe_n, .o_ext_addr, .o_ext_rd_n, .i_ext_data,
        .i_host_valid, .i_host_word, .o_host_ready, .i_link_valid,
        .i_link_data, .i_link_buffer, .o_link_ready, .o_imem_wr_en,
        .o_imem_wr, .i_imem_ready, .o_dma_channel, .o_boot_mode,
        .o_core_idle, .o_core_run, .o_core_pc, .o_ext_exec);
    rbkl_eprom_model #(.ACCESS(2)) u_eprom (.i_clk_sys(i_clk_sys),
        .i_rd_n(o_ext_rd_n), .i_cs_n(i_boot_memory_select),
        .i_addr(o_ext_addr), .o_data(i_ext_data));
    task automatic finish_test();
        $display("%0d compares, %0d mismatches", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tmo();
        chk(48'h0, 48'h1);
        finish_test();
    endtask
    function automatic logic [15:0] pat(input int i);
        return 16'(i * 40503 + 7);
    endfunction
    // 0 eprom, 1 host 16-bit, 2 host 8-bit, 3 link nibbles
    function automatic logic [47:0] exp_word(input int n);
        int ub, j;
        logic [15:0] u;
        logic [47:0] w;
        ub = (mode_sel == 1) ? 16 : (mode_sel == 3) ? 4 : 8;
        w = '0;
        for (int k = 0; k < 48 / ub; k++) begin
            j = n * (48 / ub) + k;
            u = (mode_sel == 0) ? {8'h00, 8'(j) ^ 8'(j >> 8) ^ 8'hA5} : pat(j);
            w |= 48'(u & 16'((1 << ub) - 1)) << (k * ub);
        end
        return w;
    endfunction
    always @(negedge i_clk_sys) begin
        if (!i_reset && o_imem_wr_en === 1'b1) begin
            chk(48'(o_imem_wr.addr), 48'h40000 + 48'(wcnt));
            chk(o_imem_wr.data, exp_word(wcnt));
            wcnt++;
        end
    end
    task automatic boot(input logic eb, lb, boot_memory_select, input int m);
        @(negedge i_clk_sys);
        i_reset = 1'b1;
        i_eprom_boot_select = eb;
        i_link_boot_select = lb;
        bms_strap = boot_memory_select;
        mode_sel = m;
        i_imem_ready = 1'b1;
        repeat (12) @(negedge i_clk_sys);
        wcnt = 0;
        i_reset = 1'b0;
        repeat (3) @(negedge i_clk_sys);
    endtask
    task automatic wait_rdy(input logic lvl, output bit ok);
        ok = 0;
        repeat (40) if (!ok) begin
            @(negedge i_clk_sys);
            ok = (((mode_sel == 3) ? o_link_ready : o_host_ready) === lvl);
        end
    endtask
    // 4-phase: data held with valid until ready is seen
    task automatic put(input int i, input logic [2:0] bf, output bit ok);
        logic [15:0] p;
        p = pat(i);
        @(negedge i_clk_sys);
        if (mode_sel == 3) begin
            i_link_data = p[3:0];
            i_link_buffer = bf;
            i_link_valid = 1'b1;
        end else begin
            i_host_word.wide = (mode_sel == 1);
            i_host_word.data = (mode_sel == 1) ? p : {~p[7:0], p[7:0]};
            i_host_valid = 1'b1;
        end
        wait_rdy(1'b1, ok);
    endtask
    task automatic put_end();
        bit ok;
        i_host_valid = 1'b0;
        i_link_valid = 1'b0;
        wait_rdy(1'b0, ok);
        if (!ok) tmo();
    endtask
    task automatic send(input int first, input int cnt);
        bit ok;
        for (int i = first; i < first + cnt; i++) begin
            put(i, 3'h4, ok);
            if (!ok) tmo();
            put_end();
        end
    endtask
    task automatic wait_words(input int n, input int bound);
        repeat (bound) if (wcnt < n) @(negedge i_clk_sys);
        chk(48'(wcnt), 48'(n));
        if (wcnt < n) tmo();
    endtask
    task automatic t_host8();
        boot(1'b0, 1'b0, 1'b1, 2);
        chk(o_dma_channel, RBKL_CH_EXT);
        send(0, 12);
        wait_words(2, 60);
        $display("host 8-bit partial boot done");
    endtask
    task automatic t_link();
        bit ok;
        boot(1'b0, 1'b1, 1'b1, 3);
        chk(o_boot_mode, RBKL_MODE_LINK);
        chk(o_dma_channel, RBKL_CH_LINK);
        put(0, 3'h3, ok);
        chk(ok, 1'b0);
        put_end();
        send(0, 24);
        wait_words(2, 60);
        $display("link partial boot done");
    endtask
    task automatic t_idle_modes();
        boot(1'b0, 1'b0, 1'b0, 0);
        repeat (50) @(negedge i_clk_sys);
        chk(o_boot_mode, RBKL_MODE_NOBOOT);
        chk(o_ext_exec, 1'b1);
        chk({o_ext_rd_n, 32'(wcnt)}, {1'b1, 32'h0});
        boot(1'b1, 1'b1, 1'b1, 0);
        repeat (50) @(negedge i_clk_sys);
        chk({o_core_run, o_core_idle, 32'(wcnt)}, {2'b01, 32'h0});
        $display("no-boot and reserved straps done");
    endtask
    task automatic t_eprom();
        boot(1'b1, 1'b0, 1'b1, 0);
        chk(o_dma_channel, RBKL_CH_EXT);
        repeat (10) @(negedge i_clk_sys);
        chk(o_boot_memory_select_oe_n, 1'b0);
        wait_words(256, 20000);
        repeat (60) if (o_core_run !== 1'b1) @(negedge i_clk_sys);
        chk({o_core_run, o_core_idle, o_core_pc}, {2'b10, 20'h40000});
        if (o_core_run !== 1'b1) tmo();
        chk(o_boot_memory_select_oe_n, 1'b1);
        $display("eprom boot done");
    endtask
    task automatic t_host16();
        bit ok;
        int taken;
        boot(1'b0, 1'b0, 1'b1, 1);
        i_imem_ready = 1'b0;
        ok = 1;
        taken = 0;
        while (ok && taken < 40) begin
            put(taken, 3'h4, ok);
            if (ok) put_end();
            if (ok) taken++;
        end
        // eight fifo words plus up to one word held in the packer
        chk(taken >= 24 && taken <= 27, 1'b1);
        chk(48'(wcnt), 48'h0);
        i_imem_ready = 1'b1;
        wait_rdy(1'b1, ok);
        if (!ok) tmo();
        put_end();
        send(taken + 1, 767 - taken);
        wait_words(256, 200);
        repeat (60) if (o_core_run !== 1'b1) @(negedge i_clk_sys);
        chk({o_core_run, o_core_pc}, {1'b1, 20'h40000});
        if (o_core_run !== 1'b1) tmo();
        $display("host 16-bit boot with stall done");
    endtask
    initial begin
        t_host8();
        t_link();
        t_idle_modes();
        t_eprom();
        t_host16();
        finish_test();
    end
endmodule
